// ==== rtl/pg_defines.svh ====
// shared constants of the idle paging scheduler
`ifndef PG_DEFINES_SVH
`define PG_DEFINES_SVH
`define PG_CODE_MAX    8'h1f
`define PG_TALLY_RST   8'h00
`define PG_ALL_UNITS   4'hf
`define PG_NO_UNITS    4'h0
`define PG_UNIT_CTL    0
`define PG_UNIT_SHARED 1
`define PG_UNIT_FWD    2
`define PG_UNIT_OVH    3
`define PG_QUAL_ZERO   0
`endif

// ==== rtl/pg_idle_ctl.sv ====
// idle-state paging controller: superframe counter, wake schedule, state machine
`timescale 1ns/1ns
`include "pg_defines.svh"
module pg_idle_ctl
   import pg_pkg::*;
#(
   parameter int SW = 32,
   parameter int CW = 16
) (
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          sys_rst,
   // superframe timing
   input  wire logic          sf_strobe,
   // role and configuration
   input  wire logic          role_network,
   input  wire logic [15:0]   base_cycle_unit,
   input  wire logic [7:0]    slot_code_1,
   input  wire logic [7:0]    slot_code_2,
   input  wire logic [7:0]    slot_code_3,
   input  wire logic          chosen_offset_en,
   input  wire logic [SW-1:0] chosen_offset_value,
   input  wire logic [SW-1:0] hashed_offset,
   input  wire logic [CW-1:0] first_tier_length,
   input  wire logic [CW-1:0] second_tier_end,
   input  wire logic [SW-1:0] repage_delay,
   input  wire logic          sleep_stop_en,
   input  wire logic          repage_pick,
   // commands
   input  wire logic          cmd_activate,
   input  wire logic          cmd_deactivate,
   input  wire logic          link_open_request,
   input  wire logic          cmd_close,
   input  wire logic          dereg_close,
   // indications
   input  wire logic          forward_page_hit,
   input  wire logic          control_page_hit,
   input  wire logic          address_page_msg,
   input  wire logic [31:0]   address_page_addr,
   input  wire logic [31:0]   own_address,
   input  wire logic          reverse_address_arrival,
   input  wire logic          page_error_valid,
   input  wire logic          page_error,
   input  wire logic          overhead_fresh_flag,
   // suspend and origin sources
   input  wire logic          suspend_valid,
   input  wire logic [SW-1:0] suspend_end_time,
   input  wire logic [SW-1:0] suspend_end_sf,
   input  wire logic [SW-1:0] system_time,
   input  wire logic [SW-1:0] last_rx_sf,
   // exits of access and address binding
   input  wire logic          access_to_bind,
   input  wire logic          sub_to_sleep,
   input  wire logic          sub_to_monitor,
   input  wire logic          sub_to_inactive,
   input  wire logic          tally_incr,
   // status and commands out
   output logic [2:0]         state_o,
   output logic [SW-1:0]      sf_count_o,
   output logic               wake_hit_o,
   output logic               page_tx_ok_o,
   output logic               quick_page_ok_o,
   output logic               unicast_ok_o,
   output logic               page_send_o,
   output logic               check_error_o,
   output logic [3:0]         mac_activate_o,
   output logic [3:0]         mac_deactivate_o,
   output logic [7:0]         attempt_tally_o,
   output logic               tier_reserved_o
);
   pg_state_t     st_r, st_nxt;
   logic [SW-1:0] sf_cnt_r;
   logic [SW-1:0] rp_sf_r;
   logic          rp_pend_r;
   logic          dereg_r;
   logic          bind_seen_r;
   logic          open_q_r;
   logic          served_r;
   logic [7:0]    tally_r;

   logic [SW-1:0] per1, per2, per3;
   logic [SW-1:0] next_wake, last_wake;
   logic          last_ok, sched_hit;
   logic [2:0]    code_bad;

   function automatic logic [SW-1:0] twice(input logic [SW-1:0] v);
      twice = {v[SW-2:0], 1'b0};
   endfunction : twice

   // tier intervals
   pg_tier #(.SW(SW)) u_tier1 (
      .base_cycle_unit (base_cycle_unit),
      .slot_code       (slot_code_1),
      .interval        (per1),
      .code_reserved   (code_bad[0])
   );
   pg_tier #(.SW(SW)) u_tier2 (
      .base_cycle_unit (base_cycle_unit),
      .slot_code       (slot_code_2),
      .interval        (per2),
      .code_reserved   (code_bad[1])
   );
   pg_tier #(.SW(SW)) u_tier3 (
      .base_cycle_unit (base_cycle_unit),
      .slot_code       (slot_code_3),
      .interval        (per3),
      .code_reserved   (code_bad[2])
   );

   // decoded conditions
   wire          is_term     = !role_network;
   wire [SW-1:0] cyc_offset  = chosen_offset_en ? twice(chosen_offset_value)
                                                : twice(hashed_offset);
   wire          suspend_cur = suspend_valid && (suspend_end_time > system_time);
   wire          addr_match  = address_page_msg && (address_page_addr == own_address);
   wire          page_in     = forward_page_hit || control_page_hit || addr_match;
   wire          open_any    = open_q_r || link_open_request;
   wire          rp_hit      = rp_pend_r && (sf_cnt_r == rp_sf_r);
   wire          an_rep_hit  = last_ok && (sf_cnt_r == last_wake + repage_delay);
   wire          an_wake     = repage_pick ? an_rep_hit : sched_hit;
   wire          t_wake      = (sched_hit || rp_hit) && !served_r;
   wire          may_sleep   = overhead_fresh_flag && !suspend_cur &&
                               !(sched_hit && !page_error_valid);
   wire          live        = st_r != PG_INACTIVE;

   // next state
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         PG_INACTIVE: begin
            if (cmd_activate) begin
               if (role_network || dereg_close) st_nxt = PG_SLEEP;
               else st_nxt = PG_MONITOR;
            end
         end
         PG_SLEEP: begin
            if (is_term) begin
               if (open_any) st_nxt = PG_ACCESS;
               else if (!dereg_r && t_wake) st_nxt = PG_MONITOR;
            end else begin
               if (reverse_address_arrival) st_nxt = PG_BIND;
               else if (!dereg_r && an_wake && !served_r) st_nxt = PG_MONITOR;
            end
         end
         PG_MONITOR: begin
            if (is_term) begin
               if (page_in || open_any) st_nxt = PG_ACCESS;
               else if (may_sleep) st_nxt = PG_SLEEP;
            end else begin
               if (reverse_address_arrival) st_nxt = PG_BIND;
               else if (sf_strobe) st_nxt = PG_SLEEP;
            end
         end
         PG_ACCESS: begin
            if (access_to_bind) st_nxt = PG_BIND;
            else if (sub_to_sleep) st_nxt = PG_SLEEP;
         end
         PG_BIND: begin
            if (sub_to_inactive) st_nxt = PG_INACTIVE;
            else if (sub_to_monitor) st_nxt = PG_MONITOR;
            else if (sub_to_sleep) st_nxt = PG_SLEEP;
         end
         default: st_nxt = PG_INACTIVE;
      endcase
      if (live && cmd_deactivate) st_nxt = PG_INACTIVE;
      else if (live && cmd_close) st_nxt = is_term ? PG_MONITOR : PG_SLEEP;
   end

   // transition events
   wire enter_mon   = (st_nxt == PG_MONITOR) && (st_r != PG_MONITOR);
   wire enter_sleep = (st_nxt == PG_SLEEP) && (st_r != PG_SLEEP);
   wire t_load      = is_term && enter_mon && ((st_r == PG_INACTIVE) || bind_seen_r);
   wire n_load      = role_network && (st_r == PG_INACTIVE) && enter_sleep;
   wire sched_load  = t_load || n_load;
   wire [SW-1:0] sched_origin = n_load ? (suspend_valid ? suspend_end_sf : last_rx_sf)
                                       : sf_cnt_r;
   wire err_check   = is_term && (st_r == PG_MONITOR) && sched_hit;
   wire net_page    = role_network && ((enter_mon && open_q_r) ||
                                       ((st_r == PG_MONITOR) && link_open_request));
   wire open_clr    = (st_nxt == PG_ACCESS) || (st_nxt == PG_INACTIVE) || net_page;
   wire open_set    = link_open_request && ((st_r == PG_SLEEP) || (st_r == PG_MONITOR))
                      && !(role_network && st_r == PG_MONITOR);

   pg_sched #(.SW(SW), .CW(CW)) u_sched (
      .mclk              (mclk),
      .sys_rst           (sys_rst),
      .sf_tick           (sf_strobe),
      .sf_cnt            (sf_cnt_r),
      .load              (sched_load),
      .origin            (sched_origin),
      .offset            (cyc_offset),
      .per1              (per1),
      .per2              (per2),
      .per3              (per3),
      .first_tier_length (first_tier_length),
      .second_tier_end   (second_tier_end),
      .next_wake         (next_wake),
      .last_wake         (last_wake),
      .last_ok           (last_ok),
      .hit               (sched_hit)
   );

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r     <= PG_INACTIVE;
         sf_cnt_r <= '0;
      end else begin
         st_r     <= st_nxt;
         if (sf_strobe) sf_cnt_r <= sf_cnt_r + SW'(1);
      end
   end

   // bookkeeping flags; a set always wins over a clear
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         dereg_r     <= 1'b0;
         bind_seen_r <= 1'b0;
         open_q_r    <= 1'b0;
         served_r    <= 1'b0;
      end else begin
         if (st_r == PG_INACTIVE && cmd_activate) dereg_r <= dereg_close;
         if (st_nxt == PG_BIND) bind_seen_r <= 1'b1;
         else if (enter_mon) bind_seen_r <= 1'b0;
         if (open_set) open_q_r <= 1'b1;
         else if (open_clr) open_q_r <= 1'b0;
         if (enter_mon) served_r <= 1'b1;
         else if (sf_strobe) served_r <= 1'b0;
      end
   end

   // repage request and attempt tally
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rp_pend_r <= 1'b0;
         rp_sf_r   <= '0;
         tally_r   <= `PG_TALLY_RST;
      end else begin
         if (err_check && page_error_valid) begin
            rp_pend_r <= page_error;
            rp_sf_r   <= sf_cnt_r + repage_delay;
         end else if (enter_mon && rp_hit) begin
            rp_pend_r <= 1'b0;
         end
         if ((st_r == PG_INACTIVE || (enter_mon && is_term)) && is_term)
            tally_r <= `PG_TALLY_RST;
         else if (tally_incr)
            tally_r <= tally_r + 8'h01;
      end
   end

   // registered outputs
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_o          <= PG_INACTIVE;
         sf_count_o       <= '0;
         wake_hit_o       <= 1'b0;
         page_tx_ok_o     <= 1'b0;
         quick_page_ok_o  <= 1'b0;
         unicast_ok_o     <= 1'b0;
         page_send_o      <= 1'b0;
         check_error_o    <= 1'b0;
         mac_activate_o   <= `PG_NO_UNITS;
         mac_deactivate_o <= `PG_NO_UNITS;
         attempt_tally_o  <= `PG_TALLY_RST;
         tier_reserved_o  <= 1'b0;
      end else begin
         state_o          <= st_nxt;
         sf_count_o       <= sf_cnt_r;
         wake_hit_o       <= sched_hit;
         page_tx_ok_o     <= role_network && sched_hit;
         quick_page_ok_o  <= role_network && an_rep_hit;
         unicast_ok_o     <= role_network && (st_r == PG_MONITOR);
         page_send_o      <= net_page;
         check_error_o    <= err_check;
         mac_activate_o   <= (is_term && enter_mon) ? `PG_ALL_UNITS : `PG_NO_UNITS;
         mac_deactivate_o <= (is_term && enter_sleep && sleep_stop_en)
                             ? `PG_ALL_UNITS : `PG_NO_UNITS;
         attempt_tally_o  <= tally_r;
         tier_reserved_o  <= |code_bad;
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_enter_mon;
      is_term && st_r != PG_MONITOR ##1 st_r == PG_MONITOR;
   endsequence
   sequence s_mon_to_sleep;
      is_term && st_r == PG_MONITOR ##1 st_r == PG_SLEEP;
   endsequence

   property p_sf_count;
      sf_strobe |=> sf_cnt_r == $past(sf_cnt_r) + SW'(1);
   endproperty
   a_sf_count: assert property (p_sf_count) else $error("superframe count missed");
   property p_tally_idle;
      is_term && st_r == PG_INACTIVE && !tally_incr |=> tally_r == `PG_TALLY_RST;
   endproperty
   a_tally_idle: assert property (p_tally_idle) else $error("tally not held");
   property p_mon_act;
      s_enter_mon |-> mac_activate_o == `PG_ALL_UNITS && tally_r == `PG_TALLY_RST;
   endproperty
   a_mon_act: assert property (p_mon_act) else $error("monitor entry wrong");
   property p_sleep_cond;
      s_mon_to_sleep |-> $past(overhead_fresh_flag) && !$past(suspend_cur);
   endproperty
   a_sleep_cond: assert property (p_sleep_cond) else $error("bad sleep");
   property p_open_access;
      is_term && st_r == PG_SLEEP && open_q_r && !cmd_deactivate && !cmd_close
         |=> st_r == PG_ACCESS;
   endproperty
   a_open_access: assert property (p_open_access) else $error("open ignored");
   property p_page_access;
      is_term && st_r == PG_MONITOR && page_in && !cmd_deactivate && !cmd_close
         |=> st_r == PG_ACCESS;
   endproperty
   a_page_access: assert property (p_page_access) else $error("page ignored");
   property p_dereg_net;
      role_network && dereg_r && st_r == PG_SLEEP |=> st_r != PG_MONITOR;
   endproperty
   a_dereg_net: assert property (p_dereg_net) else $error("monitor after dereg");
   property p_unicast;
      unicast_ok_o |-> $past(st_r) == PG_MONITOR && $past(role_network);
   endproperty
   a_unicast: assert property (p_unicast) else $error("unicast outside monitor");
   property p_page_tx;
      page_tx_ok_o |-> $past(sf_cnt_r) == $past(next_wake);
   endproperty
   a_page_tx: assert property (p_page_tx) else $error("page outside schedule");
   property p_rev_bind;
      role_network && st_r == PG_SLEEP && reverse_address_arrival && !cmd_deactivate
         && !cmd_close |=> st_r == PG_BIND;
   endproperty
   a_rev_bind: assert property (p_rev_bind) else $error("no binding");
endmodule : pg_idle_ctl

// ==== rtl/pg_pkg.sv ====
// types of the idle paging scheduler
package pg_pkg;
   typedef enum logic [2:0] {
      PG_INACTIVE = 3'b000,
      PG_SLEEP    = 3'b001,
      PG_MONITOR  = 3'b010,
      PG_ACCESS   = 3'b011,
      PG_BIND     = 3'b100
   } pg_state_t;
endpackage : pg_pkg

// ==== rtl/pg_sched.sv ====
// wake schedule walker: one entry at a time, three tiers
`timescale 1ns/1ns
`include "pg_defines.svh"
module pg_sched #(
   parameter int SW = 32,
   parameter int CW = 16
) (
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          sys_rst,
   // superframe timing
   input  wire logic          sf_tick,
   input  wire logic [SW-1:0] sf_cnt,
   // schedule set-up
   input  wire logic          load,
   input  wire logic [SW-1:0] origin,
   input  wire logic [SW-1:0] offset,
   input  wire logic [SW-1:0] per1,
   input  wire logic [SW-1:0] per2,
   input  wire logic [SW-1:0] per3,
   input  wire logic [CW-1:0] first_tier_length,
   input  wire logic [CW-1:0] second_tier_end,
   // schedule state
   output logic [SW-1:0]      next_wake,
   output logic [SW-1:0]      last_wake,
   output logic               last_ok,
   output logic               hit
);
   logic [SW-1:0] next_r;
   logic [SW-1:0] last_r;
   logic [CW-1:0] idx_r;
   logic          valid_r;
   logic          last_ok_r;

   // smallest t above a with (t + r) mod p equal to zero
   function automatic logic [SW-1:0] next_qual(input logic [SW-1:0] a,
                                               input logic [SW-1:0] p,
                                               input logic [SW-1:0] r);
      logic [SW-1:0] m;
      begin
         m = (p == '0) ? '0 : (a + r) % p;
         next_qual = (p == '0) ? a + SW'(1) : a + p - m;
      end
   endfunction : next_qual

   wire [CW-1:0] nidx = idx_r + 1'b1;
   wire          step = valid_r && sf_tick && (sf_cnt >= next_r);
   wire [SW-1:0] adv  = (nidx < first_tier_length)  ? next_r + per1 :
                        (nidx == first_tier_length) ? next_qual(next_r, per2, offset) :
                        (nidx < second_tier_end)    ? next_r + per2 :
                        (nidx == second_tier_end)   ? next_qual(next_r, per2, offset) :
                        next_r + per3;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         next_r    <= '0;
         last_r    <= '0;
         idx_r     <= '0;
         valid_r   <= 1'b0;
         last_ok_r <= 1'b0;
      end else if (load) begin
         next_r    <= next_qual(origin, per1, offset);
         idx_r     <= '0;
         valid_r   <= 1'b1;
         last_ok_r <= 1'b0;
      end else if (step) begin
         last_r    <= next_r;
         last_ok_r <= 1'b1;
         next_r    <= adv;
         idx_r     <= nidx;
      end
   end

   assign next_wake = next_r;
   assign last_wake = last_r;
   assign last_ok   = last_ok_r;
   assign hit       = valid_r && (sf_cnt == next_r);
endmodule : pg_sched

// ==== rtl/pg_tier.sv ====
// one tier interval from the base unit and its slot-cycle code
`timescale 1ns/1ns
`include "pg_defines.svh"
module pg_tier #(
   parameter int SW = 32
) (
   // configuration
   input  wire logic [15:0]   base_cycle_unit,
   input  wire logic [7:0]    slot_code,
   // result
   output logic [SW-1:0]      interval,
   output logic               code_reserved
);
   wire       code_ok;
   wire [4:0] shamt;

   assign code_ok       = slot_code <= `PG_CODE_MAX;
   assign code_reserved = !code_ok;
   // reserved codes are clamped to the largest legal code
   assign shamt         = code_ok ? slot_code[4:0] : 5'h1f;
   assign interval      = SW'(base_cycle_unit) << shamt;
endmodule : pg_tier

// ==== sim/pg_mac_model.sv ====
// lower mac model: makes the superframe strobe seen by the controller
`timescale 1ns/1ns
module pg_mac_model #(
   parameter int SF_LEN = 16
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // superframe timing
   output logic      sf_strobe
);
   logic [7:0] cnt_r;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r     <= 8'h00;
         sf_strobe <= 1'b0;
      end else begin
         cnt_r     <= (cnt_r == 8'(SF_LEN - 1)) ? 8'h00 : cnt_r + 8'h01;
         sf_strobe <= (cnt_r == 8'(SF_LEN - 1));
      end
   end
endmodule : pg_mac_model

// ==== sim/test_idle_paging_scheduler.sv ====
// testbench of the idle paging controller
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
`define PULSE(s) begin s <= 1'b1; @(posedge mclk); s <= 1'b0; @(posedge mclk); end
module test_idle_paging_scheduler;
   import pg_pkg::*;
   logic mclk, sys_rst, sf_strobe, role_network, chosen_offset_en, sleep_stop_en, repage_pick;
   logic cmd_activate, cmd_deactivate, link_open_request, cmd_close, dereg_close;
   logic forward_page_hit, control_page_hit, address_page_msg, reverse_address_arrival;
   logic page_error_valid, page_error, overhead_fresh_flag, suspend_valid, access_to_bind;
   logic sub_to_sleep, sub_to_monitor, sub_to_inactive, tally_incr;
   logic wake_hit_o, page_tx_ok_o, quick_page_ok_o, unicast_ok_o, page_send_o;
   logic check_error_o, tier_reserved_o;
   logic [15:0] base_cycle_unit, first_tier_length, second_tier_end;
   logic [7:0]  slot_code_1, slot_code_2, slot_code_3, attempt_tally_o;
   logic [31:0] chosen_offset_value, hashed_offset, repage_delay, suspend_end_time;
   logic [31:0] suspend_end_sf, system_time, last_rx_sf, address_page_addr, own_address;
   logic [31:0] sf_count_o, t_sf;
   logic [3:0]  mac_activate_o, mac_deactivate_o;
   logic [2:0]  state_o;
   int          miscompares, checks_done;

   pg_mac_model mac (.mclk(mclk), .sys_rst(sys_rst), .sf_strobe(sf_strobe));
   pg_idle_ctl dut (.*);

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic results();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results

   task automatic wait_st(input logic [2:0] s, input int n);
      repeat (n) if (state_o !== s) @(posedge mclk);
   endtask : wait_st

   task automatic t_terminal();
      `PULSE(tally_incr)
      `CHK(attempt_tally_o, 8'h00)
      `PULSE(cmd_activate)
      `CHK(state_o, PG_MONITOR)
      `CHK(mac_activate_o, 4'hf)
      for (int k = 0; k < 4; k++) begin
         case (k)
            0: `PULSE(forward_page_hit)
            1: `PULSE(control_page_hit)
            2: `PULSE(address_page_msg)
            default: `PULSE(link_open_request)
         endcase
         `CHK(state_o, PG_ACCESS)
         `PULSE(cmd_close)
      end
      address_page_addr <= own_address + 32'h1;
      `PULSE(address_page_msg)
      `CHK(state_o, PG_MONITOR)
      overhead_fresh_flag <= 1'b1;
      wait_st(PG_SLEEP, 40);
      `CHK(state_o, PG_SLEEP)
      `CHK(mac_deactivate_o, 4'hf)
      wait_st(PG_MONITOR, 200);
      `CHK(sf_count_o[1:0] + 2'h2, 2'h0)
      `CHK(wake_hit_o, 1'b1)
      t_sf = sf_count_o;
      @(posedge mclk);
      `CHK(check_error_o, 1'b1)
      page_error <= 1'b1;
      `PULSE(page_error_valid)
      wait_st(PG_MONITOR, 200);
      `CHK(sf_count_o, t_sf + 32'h3)
      wait_st(PG_SLEEP, 40);
      `PULSE(link_open_request)
      `CHK(state_o, PG_ACCESS)
      `PULSE(cmd_deactivate)
   endtask : t_terminal

   task automatic t_network();
      role_network <= 1'b1;
      suspend_valid <= 1'b1;
      suspend_end_sf <= sf_count_o + 32'h1;
      t_sf = sf_count_o + 32'h2;
      while (t_sf[1:0] != 2'h2) t_sf++;
      `PULSE(cmd_activate)
      `CHK(state_o, PG_SLEEP)
      `CHK(unicast_ok_o, 1'b0)
      `PULSE(link_open_request)
      wait_st(PG_MONITOR, 200);
      `CHK(sf_count_o, t_sf)
      `CHK(page_send_o, 1'b1)
      @(posedge mclk);
      @(posedge mclk);
      `CHK(unicast_ok_o, 1'b1)
      `CHK(page_tx_ok_o, 1'b1)
      wait_st(PG_SLEEP, 40);
      repeat (100) if (sf_count_o !== t_sf + 32'h3) @(posedge mclk);
      `CHK(quick_page_ok_o, 1'b1)
      `CHK(page_tx_ok_o, 1'b0)
      `PULSE(reverse_address_arrival)
      `CHK(state_o, PG_BIND)
      `PULSE(cmd_deactivate)
   endtask : t_network

   task automatic t_dereg(input logic r);
      role_network <= r;
      dereg_close <= 1'b1;
      `PULSE(cmd_activate)
      `CHK(state_o, PG_SLEEP)
      repeat (150) begin
         @(posedge mclk);
         if (state_o === PG_MONITOR) `CHK(state_o, PG_SLEEP)
      end
      `PULSE(cmd_deactivate)
      dereg_close <= 1'b0;
   endtask : t_dereg

   initial begin
      {role_network, sleep_stop_en, repage_pick, cmd_activate, cmd_deactivate} = '0;
      {link_open_request, cmd_close, dereg_close, forward_page_hit, control_page_hit} = '0;
      {address_page_msg, reverse_address_arrival, page_error_valid, page_error} = '0;
      {overhead_fresh_flag, suspend_valid, access_to_bind, sub_to_sleep} = '0;
      {sub_to_monitor, sub_to_inactive, tally_incr, hashed_offset, system_time} = '0;
      {slot_code_1, slot_code_2, slot_code_3, suspend_end_time, suspend_end_sf} = '0;
      sys_rst = 1'b1;
      sleep_stop_en = 1'b1;
      chosen_offset_en = 1'b1;
      chosen_offset_value = 32'h1;
      base_cycle_unit = 16'h0004;
      first_tier_length = 16'h0002;
      second_tier_end = 16'h0004;
      repage_delay = 32'h3;
      last_rx_sf = 32'h0;
      own_address = 32'h5a5a0001;
      address_page_addr = 32'h5a5a0001;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      `CHK(state_o, PG_INACTIVE)
      t_terminal();
      t_dereg(1'b0);
      t_network();
      t_dereg(1'b1);
      slot_code_3 <= 8'h20;
      repeat (3) @(posedge mclk);
      `CHK(tier_reserved_o, 1'b1)
      results();
   end

   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      results();
   end
endmodule : test_idle_paging_scheduler
